// *** rtl/hie2_ctrl.sv ***
// Channel-two host IRQ10/IRQ9/IRQ6 enable and request logic
// Assumes slave strobes are single-cycle pulses on clk; LPC resets are
// synchronous to clk already
`timescale 1ns/1ps
`include "hie2_regs.svh"
module hie2_ctrl
  import hie2_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      srst,
  // LPC resets
  input  wire logic      lpc_hw_reset,
  input  wire logic      lpc_sw_reset,
  // Slave access to the enable bits
  input  wire hie2_sw_t  sw_req,
  output logic [2:0]     sw_rdata,
  // Channel-two buffer state
  input  wire logic      out_buffer_full_ch2,
  input  wire logic      out_data_reg_ch2_wr,
  input  wire logic      direct_request_select,
  // Requests from other sources
  input  wire hie2_irq_t other_irq,
  // Requests to the serial interrupt output
  output hie2_irq_t      host_irq
);

  logic        obf_q_ff;
  logic        pend_ff;
  logic [2:0]  en;
  logic        obf_fall;
  logic        hw_clr;
  logic [2:0]  req;
  logic [2:0]  sw_rdata_ff;
  hie2_irq_t   host_irq_ff;

  ////////////////////////////////////////////////////////////////////////
  // Buffer flag tracking
  always_ff @(posedge clk)
  begin
    if (srst)
      obf_q_ff <= 1'b0;
    else
      obf_q_ff <= out_buffer_full_ch2;
  end

  // Flag set by a slave write to the output data register
  always_ff @(posedge clk)
  begin
    if (srst || !out_buffer_full_ch2)
      pend_ff <= 1'b0;
    else if (out_data_reg_ch2_wr)
      pend_ff <= 1'b1;
  end

  assign obf_fall = obf_q_ff && !out_buffer_full_ch2;
  assign hw_clr   = lpc_hw_reset || lpc_sw_reset ||
                    (obf_fall && !direct_request_select);

  ////////////////////////////////////////////////////////////////////////
  // Enable bits
  for (genvar i = 0; i < `HIE2_NUM_IRQ; i++)
  begin : g_en
    hie2_enable_bit u_bit (
      .clk     (clk),
      .srst    (srst),
      .sw_rd   (sw_req.rd),
      .sw_wr   (sw_req.wr),
      .sw_wbit (sw_req.wdata[i]),
      .hw_clr  (hw_clr),
      .en      (en[i])
    );
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      sw_rdata_ff <= `HIE2_EN_RESET;
    else
      sw_rdata_ff <= en;
  end

  assign sw_rdata = sw_rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Request generation
  always_comb
  begin
    if (direct_request_select)
      req = en;
    else
      req = en & {3{out_buffer_full_ch2 && pend_ff}};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      host_irq_ff <= '0;
    else
    begin
      host_irq_ff.irq10 <= req[`HIE2_BIT_IRQ10] || other_irq.irq10;
      host_irq_ff.irq9  <= req[`HIE2_BIT_IRQ9]  || other_irq.irq9;
      host_irq_ff.irq6  <= req[`HIE2_BIT_IRQ6]  || other_irq.irq6;
    end
  end

  assign host_irq = host_irq_ff;

endmodule

// *** rtl/hie2_regs.svh ***
// Constants for the channel-two host interrupt enable block
// Assumes a single 20 MHz clock domain and synchronous reset
`ifndef HIE2_REGS_SVH
`define HIE2_REGS_SVH

`define HIE2_BIT_IRQ10 2
`define HIE2_BIT_IRQ9  1
`define HIE2_BIT_IRQ6  0
`define HIE2_EN_RESET  3'h0
`define HIE2_NUM_IRQ   3

`endif

// *** rtl/hie2_pkg.sv ***
// Types for the channel-two host interrupt enable block
// Assumes the constants header is included by the modules
package hie2_pkg;

  typedef struct packed {
    logic irq10;
    logic irq9;
    logic irq6;
  } hie2_irq_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] wdata;
  } hie2_sw_t;

endpackage

// *** rtl/hie2_enable_bit.sv ***
// One enable bit with read-zero-then-write-one set condition
// Assumes all inputs are on clk; clears outrank a set
`timescale 1ns/1ps
`include "hie2_regs.svh"
module hie2_enable_bit
  import hie2_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Software access
  input  wire logic sw_rd,
  input  wire logic sw_wr,
  input  wire logic sw_wbit,
  // Hardware clear
  input  wire logic hw_clr,
  // State
  output logic      en
);

  logic en_ff;
  logic armed_ff;

  assign en = en_ff;

  ////////////////////////////////////////////////////////////////////////
  // Arm on a read that sees zero
  always_ff @(posedge clk)
  begin
    if (srst || hw_clr)
      armed_ff <= 1'b0;
    else if (sw_wr)
      armed_ff <= 1'b0;
    else if (sw_rd)
      armed_ff <= ~en_ff;
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable bit
  always_ff @(posedge clk)
  begin
    if (srst || hw_clr)
      en_ff <= 1'b0;
    else if (sw_wr && !sw_wbit)
      en_ff <= 1'b0;
    else if (sw_wr && sw_wbit && armed_ff)
      en_ff <= 1'b1;
  end

endmodule

// *** verif/hie2_monitor.sv ***
// Port assertions for hie2_ctrl
// Assumes bind into hie2_ctrl, one clock
`timescale 1ns/1ps
module hie2_monitor
  import hie2_pkg::*;
(
  input wire logic       clk, srst, lpc_hw_reset, lpc_sw_reset,
  input wire hie2_sw_t   sw_req,
  input wire logic [2:0] sw_rdata,
  input wire logic       out_buffer_full_ch2, out_data_reg_ch2_wr,
  input wire logic       direct_request_select,
  input wire hie2_irq_t  other_irq, host_irq
);
  wire n = !direct_request_select;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_rst_zero: assert property ($fell(srst) |-> !sw_rdata)
    else $error("reset");
  a_lpc_clear: assert property (lpc_hw_reset || lpc_sw_reset
    |-> ##2 !sw_rdata) else $error("lpc");
  a_zero_write: assert property (sw_req.wr && !sw_req.wdata
    |-> ##2 !sw_rdata) else $error("wr0");
  a_flag_clear: assert property (n && $fell(out_buffer_full_ch2)
    |-> ##3 !sw_rdata) else $error("flag");
  a_set_cause: assert property ($rose(sw_rdata[0]) |->
    $past(sw_req.wr, 2) && $past(sw_req.wdata[0], 2)) else $error("set");
  a_fill_req: assert property (n && out_data_reg_ch2_wr &&
    out_buffer_full_ch2 ##1 sw_rdata[1] && out_buffer_full_ch2
    |-> ##[0:2] host_irq.irq9) else $error("irq9");
  a_direct_req: assert property ($stable(n) && !n && sw_rdata[2]
    |-> host_irq.irq10) else $error("irq10");
  a_other_or: assert property (other_irq.irq6 && $past(other_irq.irq6)
    |-> host_irq.irq6) else $error("or");
  cover property (!n && host_irq.irq10);
  cover property (lpc_sw_reset);
  cover property (n && out_data_reg_ch2_wr);
endmodule
bind hie2_ctrl hie2_monitor hie2_monitor_i (.*);

// *** verif/hie2_host_model.sv ***
// Host end: records request levels
// Assumes registered requests on clk
`timescale 1ns/1ps
module hie2_host_model
  import hie2_pkg::*;
(
  input  wire logic      clk,
  input  wire hie2_irq_t host_irq,
  output hie2_irq_t      seen_irq
);
  always_ff @(posedge clk)
    seen_irq <= host_irq;
endmodule

// *** verif/test_host_irq_enable_channel_two.sv ***
// Bench for hie2_ctrl with host model
// Assumes the monitor is bound
`timescale 1ns/1ps
module test_host_irq_enable_channel_two
  import hie2_pkg::*;
;
  logic clk = 0, srst = 1, lpc_hw_reset = 0, lpc_sw_reset = 0;
  logic out_buffer_full_ch2 = 0, out_data_reg_ch2_wr = 0;
  logic direct_request_select = 0;
  logic [2:0] sw_rdata;
  hie2_sw_t sw_req = '0;
  hie2_irq_t other_irq = '0, host_irq, seen_irq;
  logic [3:0] rows [4] = '{4'h4, 4'h2, 4'h1, 4'hd};
  int fail_count = 0, compares = 0;
  hie2_ctrl hie2_ctrl_i (.*);
  hie2_host_model hie2_host_model_i (.*);
  initial forever #25 clk = ~clk;
  task chk(input logic [2:0] a, b);
    compares++;
    if (a !== b)
    begin
      $display("Error %0t: %h not %h", $time, a, b);
      fail_count++;
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task acc(input logic r, w, input logic [2:0] d);
    @(negedge clk) sw_req = '{r, w, d};
    @(negedge clk) sw_req = '0;
  endtask
  task close_out;
    $display("Mismatches %0d of %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #20000 fail_count++;
    close_out;
  end
  initial
  begin
    cyc(3); srst = 0; chk(sw_rdata, 3'h0);
    foreach (rows[i])
    begin
      direct_request_select = rows[i][3];
      acc(1, 0, 3'h0); acc(0, 1, rows[i][2:0]);
      out_buffer_full_ch2 = 1; out_data_reg_ch2_wr = 1;
      cyc(1); out_data_reg_ch2_wr = 0; cyc(4);
      chk(seen_irq, rows[i][2:0]);
      out_buffer_full_ch2 = 0; cyc(4);
      chk(sw_rdata, rows[i][3] ? rows[i][2:0] : 3'h0);
      acc(0, 1, 3'h0); cyc(3); chk(seen_irq, 3'h0);
    end
    acc(0, 1, 3'h7); cyc(2); chk(sw_rdata, 3'h0);
    acc(1, 0, 3'h0); acc(0, 1, 3'h7); cyc(2); chk(sw_rdata, 3'h7);
    lpc_hw_reset = 1; cyc(1); lpc_hw_reset = 0; cyc(2);
    chk(sw_rdata, 3'h0);
    acc(1, 0, 3'h0); acc(0, 1, 3'h3); lpc_sw_reset = 1; cyc(1);
    lpc_sw_reset = 0; cyc(2); chk(sw_rdata, 3'h0);
    other_irq = 3'h5; cyc(3); chk(seen_irq, 3'h5);
    other_irq = 3'h2; cyc(3); chk(seen_irq, 3'h2);
    other_irq = 3'h0; acc(1, 0, 3'h0); acc(0, 1, 3'h7);
    srst = 1; cyc(1); srst = 0; cyc(2);
    chk(sw_rdata, 3'h0);
    chk(seen_irq, 3'h0);
    close_out;
  end
endmodule
